//--- design/indirect_data_memory_access.sv
/*
 * Indirect data memory access: two pointers, two redirecting port
 * locations, bank select and the banked store behind them.
 * Assumes the core issues at most one access per cycle and uses
 * read-then-write for read-modify-write instructions.
 */
`timescale 1ns/100ps
`default_nettype none
module indirect_data_memory_access
	import indirect_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              warm_rst,
	input  wire logic              warm_rst_keep_bank,
	input  wire logic              acc_valid,
	input  wire logic              acc_write,
	input  wire logic [DATA_W-1:0] acc_addr,
	input  wire logic [DATA_W-1:0] acc_wdata,
	output var  logic [DATA_W-1:0] acc_rdata,
	output var  logic [BANK_W-1:0] bank_sel
);
	logic [DATA_W-1:0] ptr_zero_reg;
	logic [DATA_W-1:0] ptr_one_reg;
	logic [BANK_W-1:0] bank_reg;
	logic [FULL_W-1:0] eff_addr;
	logic [DATA_W-1:0] eff_off;
	logic              in_common;
	logic              lands_null;
	logic              wr_req;
	logic              rd_req;
	logic [DATA_W-1:0] rdata_next;

	ram_bus_if #(.ADDR_W(FULL_W), .DATA_W(DATA_W)) ram_bus ();

	banked_store banked_store_i (
		.mclk (mclk),
		.bus  (ram_bus.mem)
	);

	function automatic logic [FULL_W-1:0] resolve(
		input logic [DATA_W-1:0] addr,
		input logic [DATA_W-1:0] p0,
		input logic [DATA_W-1:0] p1,
		input logic [BANK_W-1:0] bank
	);
		logic [FULL_W-1:0] r;
		r = {BANK_ZERO, addr};
		if (addr == ADDR_PORT_ZERO) begin
			r = {BANK_ZERO, p0};
		end else if (addr == ADDR_PORT_ONE) begin
			r = {bank, p1};
		end
		return r;
	endfunction

	function automatic logic is_port(input logic [DATA_W-1:0] off);
		return (off == ADDR_PORT_ZERO) || (off == ADDR_PORT_ONE);
	endfunction

	// Only one level of redirection: a pointer naming a port lands on nothing
	always_comb begin
		eff_addr   = resolve(acc_addr, ptr_zero_reg, ptr_one_reg, bank_reg);
		eff_off    = eff_addr[DATA_W-1:0];
		in_common  = eff_off < COMMON_TOP;
		lands_null = in_common && is_port(eff_off);
		wr_req     = acc_valid && acc_write && !lands_null;
		rd_req     = acc_valid && !acc_write;
	end

	always_comb begin
		ram_bus.addr  = eff_addr;
		ram_bus.wdata = acc_wdata;
		ram_bus.we    = wr_req && !(in_common && (eff_off == ADDR_PTR_ZERO
			|| eff_off == ADDR_PTR_ONE || eff_off == ADDR_BANK_SEL));
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_zero_reg <= PTR_RESET;
		end else if (wr_req && in_common && eff_off == ADDR_PTR_ZERO) begin
			ptr_zero_reg <= acc_wdata;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_one_reg <= PTR_RESET;
		end else if (wr_req && in_common && eff_off == ADDR_PTR_ONE) begin
			ptr_one_reg <= acc_wdata;
		end
	end

	// A clearing warm reset wins over a bank write in the same cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bank_reg <= BANK_RESET;
		end else if (warm_rst && !warm_rst_keep_bank) begin
			bank_reg <= BANK_RESET;
		end else if (wr_req && in_common && eff_off == ADDR_BANK_SEL) begin
			bank_reg <= acc_wdata[BANK_W-1:0];
		end
	end

	always_comb begin
		rdata_next = ram_bus.rdata;
		if (lands_null) begin
			rdata_next = NULL_READ;
		end else if (in_common && eff_off == ADDR_PTR_ZERO) begin
			rdata_next = ptr_zero_reg;
		end else if (in_common && eff_off == ADDR_PTR_ONE) begin
			rdata_next = ptr_one_reg;
		end else if (in_common && eff_off == ADDR_BANK_SEL) begin
			rdata_next = {BANK_PAD, bank_reg};
		end
	end

	// Read data holds until the next read so the core may sample late
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_rdata <= NULL_READ;
		end else if (rd_req) begin
			acc_rdata <= rdata_next;
		end
	end

	assign bank_sel = bank_reg;

	// Properties watch the core's own drive as well as resolved addresses and stored state
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// Async clear is judged at the first edge after release, before any access lands
	a_reset_clears_bank: assert property (
		$fell(sys_rst) |-> bank_sel == BANK_RESET && ptr_zero_reg == PTR_RESET
			&& ptr_one_reg == PTR_RESET)
		else $error("reset left bank select or pointers set");

	a_port_never_stored: assert property (
		ram_bus.we |-> !(in_common && is_port(eff_off)))
		else $error("port location written as storage");

	a_store_port0_bank: assert property (
		acc_valid && acc_addr == ADDR_PORT_ZERO |-> ram_bus.addr[FULL_W-1:DATA_W] == BANK_ZERO)
		else $error("store saw first port access outside bank zero");

	a_ptr_zero_store: assert property (
		wr_req && in_common && eff_off == ADDR_PTR_ZERO |=> ptr_zero_reg == $past(acc_wdata))
		else $error("first pointer did not store written value");

	a_ptr_one_store: assert property (
		wr_req && in_common && eff_off == ADDR_PTR_ONE |=> ptr_one_reg == $past(acc_wdata))
		else $error("second pointer register missed a write");

	a_bank_write_low: assert property (
		wr_req && in_common && eff_off == ADDR_BANK_SEL
		&& !(warm_rst && !warm_rst_keep_bank)
		|=> bank_sel == $past(acc_wdata[BANK_W-1:0]))
		else $error("bank select did not take low write bits");

	a_port_read_zero: assert property (
		rd_req && lands_null |=> acc_rdata == NULL_READ)
		else $error("read landing on a port did not return zero");

	a_port_write_nop: assert property (
		acc_valid && acc_write && lands_null && !warm_rst
		|-> !ram_bus.we ##1 $stable(ptr_zero_reg) && $stable(ptr_one_reg)
			&& $stable(bank_reg))
		else $error("write landing on a port changed state");

	a_port0_redirect: assert property (
		acc_valid && acc_addr == ADDR_PORT_ZERO |-> eff_off == ptr_zero_reg)
		else $error("first port not redirected to first pointer");

	a_port0_bank_zero: assert property (
		acc_valid && acc_addr == ADDR_PORT_ZERO
		|-> eff_addr[FULL_W-1:DATA_W] == BANK_ZERO)
		else $error("first port left bank zero");

	a_port1_bank_follow: assert property (
		acc_valid && acc_addr == ADDR_PORT_ONE |-> eff_addr == {bank_sel, ptr_one_reg})
		else $error("second port did not follow bank and pointer");

	a_direct_bank_zero: assert property (
		acc_valid && !is_port(acc_addr) |-> eff_addr == {BANK_ZERO, acc_addr})
		else $error("direct access left bank zero");

	// One idle cycle between write and read, as a one-access-per-two-cycle core issues them
	a_ptr_write_read: assert property (
		acc_valid && acc_write && !lands_null && in_common
		&& eff_off == ADDR_PTR_ONE ##1 !acc_valid
		##1 rd_req && acc_addr == ADDR_PTR_ONE
		|=> acc_rdata == $past(acc_wdata, 3))
		else $error("second pointer did not store written value");

	a_bank_upper_zero: assert property (
		rd_req && acc_addr == ADDR_BANK_SEL |=> acc_rdata[DATA_W-1:BANK_W] == BANK_PAD)
		else $error("bank select upper bits not zero");

	a_bank_warm_clear: assert property (
		warm_rst && !warm_rst_keep_bank |=> bank_sel == BANK_RESET)
		else $error("warm reset did not clear bank select");

	a_bank_warm_keep: assert property (
		warm_rst && warm_rst_keep_bank && !(wr_req && in_common
		&& eff_off == ADDR_BANK_SEL) |=> $stable(bank_sel))
		else $error("watchdog sleep reset changed bank select");

	c_far_bank_read: cover property (
		rd_req && acc_addr == ADDR_PORT_ONE && bank_sel != BANK_ZERO);
	c_port0_write: cover property (acc_valid && acc_write && acc_addr == ADDR_PORT_ZERO);
	c_null_read: cover property (rd_req && lands_null);
	c_keep_bank: cover property (warm_rst && warm_rst_keep_bank && bank_sel != BANK_ZERO);
	c_warm_clear: cover property (warm_rst && !warm_rst_keep_bank && bank_sel != BANK_ZERO);
endmodule
`default_nettype wire

//--- design/indirect_pkg.sv
/*
 * Shared constants for the indirect data memory access block:
 * special register locations, bank layout, reset values and widths.
 * Assumes an 8-bit operand address from the instruction core and
 * four data memory banks behind a common special register area.
 */
`default_nettype none
package indirect_pkg;
	localparam int          DATA_W        = 8;
	localparam int          BANK_W        = 2;
	localparam int          FULL_W        = BANK_W + DATA_W;
	localparam logic [7:0]  ADDR_PORT_ZERO = 8'h00;
	localparam logic [7:0]  ADDR_PTR_ZERO  = 8'h01;
	localparam logic [7:0]  ADDR_PORT_ONE  = 8'h02;
	localparam logic [7:0]  ADDR_PTR_ONE   = 8'h03;
	localparam logic [7:0]  ADDR_BANK_SEL  = 8'h04;
	// Offsets below this are the common area, shared by every bank
	localparam logic [7:0]  COMMON_TOP     = 8'h80;
	localparam logic [1:0]  BANK_ZERO      = 2'h0;
	localparam logic [1:0]  BANK_RESET     = 2'h0;
	localparam logic [7:0]  PTR_RESET      = 8'h00;
	localparam logic [7:0]  NULL_READ      = 8'h00;
	localparam logic [5:0]  BANK_PAD       = 6'h00;
endpackage
`default_nettype wire

//--- design/ram_bus_if.sv
/*
 * Carrier between the address resolver and the banked data store.
 * Assumes one access per cycle, combinational read data.
 */
`timescale 1ns/100ps
`default_nettype none
interface ram_bus_if #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 8
);
	logic              we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- design/banked_store.sv
/*
 * Banked byte store. The common area is folded onto bank 0 so that
 * special locations read the same whatever bank is named.
 * Assumes the controller never writes the pointer or port locations.
 */
`timescale 1ns/100ps
`default_nettype none
module banked_store
	import indirect_pkg::*;
(
	input  wire logic mclk,
	ram_bus_if.mem    bus
);
	localparam int DEPTH = 1 << FULL_W;

	logic [DATA_W-1:0] mem_array [DEPTH];
	logic [FULL_W-1:0] index;

	always_comb begin
		index = bus.addr;
		if (bus.addr[DATA_W-1:0] < COMMON_TOP) begin
			index[FULL_W-1:DATA_W] = BANK_ZERO;
		end
	end

	// No reset: plain RAM content is undefined after power-up
	always_ff @(posedge mclk) begin
		if (bus.we) begin
			mem_array[index] <= bus.wdata;
		end
	end

	assign bus.rdata = mem_array[index];
endmodule
`default_nettype wire

//--- sim/core_model.sv
/*
 * Instruction core model: issues one byte access per call on the access port.
 * Assumes a single calling process and reset already released.
 */
`timescale 1ns/100ps
`default_nettype none
module core_model
	import indirect_pkg::*;
(
	input  wire logic              mclk,
	output var  logic              acc_valid,
	output var  logic              acc_write,
	output var  logic [DATA_W-1:0] acc_addr,
	output var  logic [DATA_W-1:0] acc_wdata,
	input  wire logic [DATA_W-1:0] acc_rdata
);
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_addr = 8'h00;
		acc_wdata = 8'h00;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		@(posedge mclk);
		acc_valid <= 1'b1;
		acc_write <= w;
		acc_addr <= a;
		acc_wdata <= d;
		@(posedge mclk);
		acc_valid <= 1'b0;
		// Released lines flip so a stale value is never trusted
		acc_addr <= ~a;
		acc_wdata <= ~d;
		#1 r = acc_rdata;
	endtask
endmodule
`default_nettype wire

//--- sim/indirect_data_memory_access_tb.sv
/*
 * Self-checking bench for the indirect data memory access block.
 * Assumes the core model for accesses; warm reset driven here.
 */
`timescale 1ns/100ps
`default_nettype none
module indirect_data_memory_access_tb
	import indirect_pkg::*;
;
	logic       mclk, sys_rst, warm_rst, warm_rst_keep_bank;
	logic       acc_valid, acc_write;
	logic [7:0] acc_addr, acc_wdata, acc_rdata, rd;
	logic [1:0] bank_sel;
	int         num_errors, n_checks, cycles;

	indirect_data_memory_access indirect_data_memory_access_i (.mclk(mclk),
		.sys_rst(sys_rst), .warm_rst(warm_rst), .warm_rst_keep_bank(warm_rst_keep_bank),
		.acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .bank_sel(bank_sel));
	core_model core_model_i (.mclk(mclk), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		core_model_i.xfer(1'b1, a, d, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		core_model_i.xfer(1'b0, a, 8'h00, rd);
		check(rd, exp);
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic test_reset;
		check({BANK_PAD, bank_sel}, 8'h00);
		rd_chk(ADDR_PTR_ZERO, PTR_RESET);
		rd_chk(ADDR_BANK_SEL, 8'h00);
	endtask
	task automatic test_ports;
		wr(ADDR_PTR_ZERO, 8'h90);
		wr(ADDR_PORT_ZERO, 8'hA5);
		rd_chk(8'h90, 8'hA5);
		wr(ADDR_BANK_SEL, 8'hFF);
		check({BANK_PAD, bank_sel}, 8'h03);
		rd_chk(ADDR_BANK_SEL, 8'h03);
		rd_chk(ADDR_PORT_ZERO, 8'hA5);
		wr(ADDR_PTR_ONE, 8'h90);
		wr(ADDR_PORT_ONE, 8'h3C);
		rd_chk(8'h90, 8'hA5);
		rd_chk(ADDR_PORT_ONE, 8'h3C);
	endtask
	task automatic test_banks;
		wr(ADDR_PTR_ONE, 8'h91);
		rd_chk(ADDR_PTR_ONE, 8'h91);
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_BANK_SEL, 8'(b));
			wr(ADDR_PORT_ONE, 8'(8'h10 + b));
		end
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_BANK_SEL, 8'(b));
			check({BANK_PAD, bank_sel}, 8'(b));
			rd_chk(ADDR_PORT_ONE, 8'(8'h10 + b));
		end
	endtask
	task automatic test_null;
		wr(ADDR_PTR_ZERO, ADDR_PORT_ONE);
		rd_chk(ADDR_PORT_ZERO, NULL_READ);
		wr(ADDR_PORT_ZERO, 8'h77);
		rd_chk(ADDR_PORT_ONE, 8'h13);
		rd_chk(ADDR_PTR_ONE, 8'h91);
		wr(ADDR_PTR_ZERO, rd + 8'h01);
		rd_chk(ADDR_PTR_ZERO, 8'h92);
	endtask
	task automatic test_warm;
		wr(ADDR_BANK_SEL, 8'h02);
		for (int k = 1; k >= 0; k--) begin
			@(posedge mclk);
			warm_rst <= 1'b1;
			warm_rst_keep_bank <= k[0];
			@(posedge mclk);
			warm_rst <= 1'b0;
			#1 check({BANK_PAD, bank_sel}, k ? 8'h02 : 8'h00);
		end
	endtask
	task automatic test_midreset;
		wr(ADDR_BANK_SEL, 8'h01);
		wr(ADDR_PTR_ONE, 8'h55);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		#1 check({BANK_PAD, bank_sel}, 8'h00);
		rd_chk(ADDR_PTR_ONE, PTR_RESET);
		rd_chk(ADDR_BANK_SEL, 8'h00);
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		sys_rst = 1'b1;
		warm_rst = 1'b0;
		warm_rst_keep_bank = 1'b0;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		#1 test_reset();
		test_ports();
		test_banks();
		test_null();
		test_warm();
		test_midreset();
		print_verdict();
	end
endmodule
`default_nettype wire
